// *** sr_latch_consts.svh ***
`ifndef SR_LATCH_CONSTS_SVH
`define SR_LATCH_CONSTS_SVH

// ==========================================================================
// Register byte addresses
`define ADDR_LATCH_CONTROL_PRIMARY 4'h0
`define ADDR_LATCH_SOURCE_ENABLES  4'h4
`define ADDR_LATCH_STATUS          4'h8

// ==========================================================================
// Field positions, first control register
`define BIT_MODULE_ENABLE    7
`define BIT_SEL_HI           6
`define BIT_SEL_LO           4
`define BIT_TRUE_OUT_EN      3
`define BIT_COMPL_OUT_EN     2
`define BIT_SOFT_SET_PULSE   1
`define BIT_SOFT_RESET_PULSE 0

// ==========================================================================
// Field positions, source enable register
`define BIT_PIN_SET_EN     7
`define BIT_CLOCK_SET_EN   6
`define BIT_CMP2_SET_EN    5
`define BIT_CMP1_SET_EN    4
`define BIT_PIN_RESET_EN   3
`define BIT_CLOCK_RESET_EN 2
`define BIT_CMP2_RESET_EN  1
`define BIT_CMP1_RESET_EN  0

// ==========================================================================
// Reset values and timing
`define RST_CONTROL_PRIMARY 8'h00
`define RST_SOURCE_ENABLES  8'h00
`define MIN_DIV_LOG2        2
`define DIV_CNT_W           9
`define QCLK_DIV            4

`endif

// *** sr_latch_pkg.sv ***
package sr_latch_pkg;
   typedef logic [7:0] reg8_t;
   typedef logic [1:0] axi_resp_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_t;
endpackage

// *** periodic_pulse_gen.sv ***
`timescale 1ns/10ps
`include "sr_latch_consts.svh"

module periodic_pulse_gen (
   input  wire logic       clk_sys,  // System clock
   input  wire logic       nrst,     // Async reset, active low
   input  wire logic [2:0] sel,      // Period code, N = 4 << sel
   output logic            pulse     // One-cycle pulse every N cycles
);
   import sr_latch_pkg::*;

   logic [`DIV_CNT_W-1:0] cnt_q;
   logic [`DIV_CNT_W-1:0] mask;

   // Free-running counter, no reset dependence on code
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;   // [R18]
      end
   end

   // Low bits of the counter define the period
   // Shift amount needs four bits: code 111 shifts by 9 and wraps to all ones
   always_comb begin
      mask  = `DIV_CNT_W'((`DIV_CNT_W'(1) << (4'(`MIN_DIV_LOG2) + 4'(sel))) - 1'b1);
      pulse = ((cnt_q & mask) == mask);   // [R4]
   end
endmodule

// *** sr_latch_unit.sv ***
`timescale 1ns/10ps
`include "sr_latch_consts.svh"
// What this block does
// [R1] Latch follows active-high set and reset inputs without a clock edge; here state_q changes only on the clk_sys rising edge.
// [R2] Set and reset high together: latch goes to and holds reset.
// [R3] Software set/reset bits pulse latch input one Q-clock, read as zero.
// [R4] Periodic pulse one cycle wide every 4 to 512 cycles by code.
// [R5] Clock-set and clock-reset enables route periodic pulse to latch inputs.
// [R6] Comparator set enables set latch while comparator output is high.
// [R7] Comparator reset enables reset latch while comparator output is high.
// [R8] Pin enables let external input pin set or reset latch.
// [R9] Module enable gates the latch; disabled means output enables ignored; here only the output enables are gated and state_q still updates.
// [R10] Enabled module with true-output enable drives true output pin.
// [R11] Enabled module with complement enable drives complement pin; both allowed.
// [R12] Device reset leaves latch state undefined.
// [R13] Software puts latch in known state before enabling output pins.
// [R14] Software avoids enabling one source for both set and reset.
// [R15] Software clears pin direction bit so the pin driver works.
// [R16] Comparator inputs arrive already synchronised by the comparator block.
// [R17] Both control registers reset to zero on every reset.
// [R18] Combined inputs are ORs of enabled sources; divider runs freely.

module sr_latch_unit (
   input  wire logic        clk_sys,           // System clock, 250 MHz
   input  wire logic        nrst,              // Async reset, active low
   input  wire logic [3:0]  s_axi_awaddr,      // Write address
   input  wire logic        s_axi_awvalid,     // Write address valid
   output logic             s_axi_awready,     // Write address ready
   input  wire logic [31:0] s_axi_wdata,       // Write data
   input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes
   input  wire logic        s_axi_wvalid,      // Write data valid
   output logic             s_axi_wready,      // Write data ready
   output sr_latch_pkg::axi_resp_t s_axi_bresp, // Write response
   output logic             s_axi_bvalid,      // Write response valid
   input  wire logic        s_axi_bready,      // Write response ready
   input  wire logic [3:0]  s_axi_araddr,      // Read address
   input  wire logic        s_axi_arvalid,     // Read address valid
   output logic             s_axi_arready,     // Read address ready
   output logic [31:0]      s_axi_rdata,       // Read data
   output sr_latch_pkg::axi_resp_t s_axi_rresp, // Read response
   output logic             s_axi_rvalid,      // Read data valid
   input  wire logic        s_axi_rready,      // Read data ready
   input  wire logic        cmp1_synced_out,   // Comparator 1 output
   input  wire logic        cmp2_synced_out,   // Comparator 2 output
   input  wire logic        latch_ext_input_pin, // External latch input
   output logic             true_out_pin,      // True output level
   output logic             true_out_pin_oe,   // True output drive enable
   output logic             compl_out_pin,     // Complement output level
   output logic             compl_out_pin_oe   // Complement output drive enable
);
   import sr_latch_pkg::*;

   // ======================================================================
   // Registers and internal signals
   reg8_t      latch_control_primary_q;
   reg8_t      latch_source_enables_q;
   logic       soft_set_pulse_q;
   logic       soft_reset_pulse_q;
   logic [1:0] qclk_cnt_q;
   logic       soft_set_pend_q;
   logic       soft_reset_pend_q;
   logic       state_q;
   logic       periodic_pulse;
   logic       set_in;
   logic       reset_in;
   logic       aw_held_q;
   logic       w_held_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   rd_state_t  rd_state_q;

   function automatic logic known_addr(input logic [3:0] a);
      known_addr = (a == `ADDR_LATCH_CONTROL_PRIMARY) || (a == `ADDR_LATCH_SOURCE_ENABLES)
                   || (a == `ADDR_LATCH_STATUS);
   endfunction

   // ======================================================================
   // Write channel: address and data captured in either order
   wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= 4'h0;
         wdata_q       <= 32'h0;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_addr(awaddr_q) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire wr_ctrl = do_write && wstrb_q[0] && (awaddr_q == `ADDR_LATCH_CONTROL_PRIMARY);
   wire wr_srcs = do_write && wstrb_q[0] && (awaddr_q == `ADDR_LATCH_SOURCE_ENABLES);

   // ======================================================================
   // Control registers; pulse bits are never stored
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         latch_control_primary_q <= `RST_CONTROL_PRIMARY;   // [R17]
         latch_source_enables_q  <= `RST_SOURCE_ENABLES;    // [R17]
      end else begin
         if (wr_ctrl) begin
            latch_control_primary_q <= {wdata_q[7:2], 2'b00};   // [R3]
         end
         if (wr_srcs) begin
            latch_source_enables_q <= wdata_q[7:0];
         end
      end
   end

   // ======================================================================
   // Software pulses: held until the next Q-clock boundary, then one Q-clock
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         qclk_cnt_q         <= 2'b00;
         soft_set_pend_q    <= 1'b0;
         soft_reset_pend_q  <= 1'b0;
         soft_set_pulse_q   <= 1'b0;
         soft_reset_pulse_q <= 1'b0;
      end else begin
         qclk_cnt_q <= qclk_cnt_q + 2'b01;
         if (qclk_cnt_q == 2'(`QCLK_DIV - 1)) begin
            soft_set_pulse_q   <= soft_set_pend_q;     // [R3]
            soft_reset_pulse_q <= soft_reset_pend_q;   // [R3]
            soft_set_pend_q    <= wr_ctrl && wdata_q[`BIT_SOFT_SET_PULSE];
            soft_reset_pend_q  <= wr_ctrl && wdata_q[`BIT_SOFT_RESET_PULSE];
         end else begin
            soft_set_pend_q    <= soft_set_pend_q || (wr_ctrl && wdata_q[`BIT_SOFT_SET_PULSE]);
            soft_reset_pend_q  <= soft_reset_pend_q
                                  || (wr_ctrl && wdata_q[`BIT_SOFT_RESET_PULSE]);
         end
      end
   end

   // ======================================================================
   // Periodic pulse source
   periodic_pulse_gen i_periodic_pulse_gen (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sel     (latch_control_primary_q[`BIT_SEL_HI:`BIT_SEL_LO]),
      .pulse   (periodic_pulse)
   );

   // ======================================================================
   // Combined set and reset inputs
   // Comparator inputs are taken as already synchronised upstream [R16]
   always_comb begin
      set_in = soft_set_pulse_q
             | (latch_source_enables_q[`BIT_CLOCK_SET_EN] & periodic_pulse)       // [R5]
             | (latch_source_enables_q[`BIT_CMP2_SET_EN] & cmp2_synced_out)       // [R6]
             | (latch_source_enables_q[`BIT_CMP1_SET_EN] & cmp1_synced_out)       // [R6]
             | (latch_source_enables_q[`BIT_PIN_SET_EN] & latch_ext_input_pin);   // [R8]
      reset_in = soft_reset_pulse_q
             | (latch_source_enables_q[`BIT_CLOCK_RESET_EN] & periodic_pulse)     // [R5]
             | (latch_source_enables_q[`BIT_CMP2_RESET_EN] & cmp2_synced_out)     // [R7]
             | (latch_source_enables_q[`BIT_CMP1_RESET_EN] & cmp1_synced_out)     // [R7]
             | (latch_source_enables_q[`BIT_PIN_RESET_EN] & latch_ext_input_pin); // [R8] [R18]
   end

   // ======================================================================
   // Latch state: reset dominant, no device reset applied
   always_ff @(posedge clk_sys) begin   // [R12]
      if (reset_in) begin
         state_q <= 1'b0;               // [R2]
      end else if (set_in) begin
         state_q <= 1'b1;               // [R1]
      end
   end

   // ======================================================================
   // Output pins
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         true_out_pin     <= 1'b0;
         compl_out_pin    <= 1'b1;
         true_out_pin_oe  <= 1'b0;
         compl_out_pin_oe <= 1'b0;
      end else begin
         true_out_pin     <= state_q;
         compl_out_pin    <= !state_q;
         true_out_pin_oe  <= latch_control_primary_q[`BIT_MODULE_ENABLE]
                             & latch_control_primary_q[`BIT_TRUE_OUT_EN];   // [R9] [R10]
         compl_out_pin_oe <= latch_control_primary_q[`BIT_MODULE_ENABLE]
                             & latch_control_primary_q[`BIT_COMPL_OUT_EN];  // [R9] [R11]
      end
   end

   // ======================================================================
   // Read channel
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_state_q    <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'b00;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               s_axi_arready <= s_axi_arvalid && !s_axi_arready;
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rresp   <= known_addr(s_axi_araddr) ? 2'b00 : 2'b10;
                  case (s_axi_araddr)
                     `ADDR_LATCH_CONTROL_PRIMARY: s_axi_rdata <= {24'h0, latch_control_primary_q};
                     `ADDR_LATCH_SOURCE_ENABLES:  s_axi_rdata <= {24'h0, latch_source_enables_q};
                     `ADDR_LATCH_STATUS:          s_axi_rdata <= {31'h0, state_q};
                     default:                     s_axi_rdata <= 32'h0;
                  endcase
                  rd_state_q <= RD_RESP;
               end
            end
            RD_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_q   <= RD_IDLE;
               end
            end
            default: begin
               rd_state_q <= RD_IDLE;
            end
         endcase
      end
   end
endmodule

// *** sr_latch_unit_assertions.sv ***
`timescale 1ns/10ps
`include "sr_latch_consts.svh"
// ==========================================================================
// Port-level checks of the latch unit
module sr_latch_chk (
   input wire logic        clk_sys,             // Clock
   input wire logic        nrst,                // Reset
   input wire logic [3:0]  s_axi_awaddr,        // Write address
   input wire logic        s_axi_awvalid,       // Write address valid
   input wire logic        s_axi_awready,       // Write address ready
   input wire logic [31:0] s_axi_wdata,         // Write data
   input wire logic [3:0]  s_axi_wstrb,         // Write strobes
   input wire logic        s_axi_wvalid,        // Write data valid
   input wire logic        s_axi_wready,        // Write data ready
   input wire logic        s_axi_bvalid,        // Write response valid
   input wire logic        s_axi_bready,        // Write response ready
   input wire logic [31:0] s_axi_rdata,         // Read data
   input wire logic        s_axi_rvalid,        // Read data valid
   input wire logic        cmp1_synced_out,     // Comparator 1
   input wire logic        cmp2_synced_out,     // Comparator 2
   input wire logic        latch_ext_input_pin, // External input
   input wire logic        true_out_pin,        // True output
   input wire logic        true_out_pin_oe,     // True output enable
   input wire logic        compl_out_pin,       // Complement output
   input wire logic        compl_out_pin_oe     // Complement output enable
);
   logic [3:0] a_q;
   logic [7:0] d_q, ctl_q, en_q;
   logic       w0_q, set_c, rst_c;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Shadow copies of both control registers, committed at the response
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         a_q <= 4'h0;
         d_q <= 8'h00;
         w0_q <= 1'b0;
         ctl_q <= 8'h00;
         en_q <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata[7:0];
         if (s_axi_wvalid && s_axi_wready) w0_q <= s_axi_wstrb[0];
         if (s_axi_bvalid && s_axi_bready && w0_q && a_q == `ADDR_LATCH_CONTROL_PRIMARY)
            ctl_q <= d_q;
         if (s_axi_bvalid && s_axi_bready && w0_q && a_q == `ADDR_LATCH_SOURCE_ENABLES)
            en_q <= d_q;
      end
   end
   assign set_c = (en_q[7] & latch_ext_input_pin) | (en_q[5] & cmp2_synced_out)
                | (en_q[4] & cmp1_synced_out);
   assign rst_c = (en_q[3] & latch_ext_input_pin) | (en_q[1] & cmp2_synced_out)
                | (en_q[0] & cmp1_synced_out);
   property p_set; set_c && !rst_c |-> ##[2:3] true_out_pin; endproperty
   property p_rst; rst_c |-> ##[2:3] !true_out_pin; endproperty
   property p_toe; $stable(ctl_q) [*3] |-> true_out_pin_oe == (ctl_q[7] && ctl_q[3]); endproperty
   property p_coe; $stable(ctl_q) [*3] |-> compl_out_pin_oe == (ctl_q[7] && ctl_q[2]); endproperty
   property p_compl; true_out_pin_oe || compl_out_pin_oe |-> compl_out_pin != true_out_pin;
   endproperty
   property p_rdz; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
   property p_wresp; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_set: assert property (p_set)
      else $error("latch not set by enabled source");
   a_rst: assert property (p_rst)
      else $error("latch not reset by enabled source");
   a_toe: assert property (p_toe)
      else $error("true output enable mismatch");
   a_coe: assert property (p_coe)
      else $error("complement output enable mismatch");
   a_compl: assert property (p_compl)
      else $error("outputs not complementary");
   a_rdz: assert property (p_rdz) else $error("upper read bits not zero");
   a_wresp: assert property (p_wresp) else $error("write response missing");
   a_bdone: assert property (p_bdone) else $error("write response repeated");
   c_set: cover property (set_c && !rst_c);
   c_both: cover property (set_c && rst_c);
   c_oe: cover property (true_out_pin_oe && compl_out_pin_oe);
endmodule

// *** src_model.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Comparator and input pin levels seen by the latch
module src_model (
   output logic cmp1_synced_out,     // Comparator 1 level
   output logic cmp2_synced_out,     // Comparator 2 level
   output logic latch_ext_input_pin  // External input level
);
   initial {latch_ext_input_pin, cmp2_synced_out, cmp1_synced_out} = 3'b000;
   // Caller invokes this at a clock edge, so levels arrive already synchronised
   task put(input logic [2:0] v);
      {latch_ext_input_pin, cmp2_synced_out, cmp1_synced_out} <= v;
   endtask
endmodule

// *** set_reset_latch_unit_tb.sv ***
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench
module set_reset_latch_unit_tb;
   import sr_latch_pkg::*;
   logic        clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, cmp1_synced_out, cmp2_synced_out, latch_ext_input_pin;
   logic        true_out_pin, true_out_pin_oe, compl_out_pin, compl_out_pin_oe;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   axi_resp_t   s_axi_bresp, s_axi_rresp;
   int          fail_count, cmp_count, cyc, n;
   sr_latch_unit i_sr_latch_unit (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp1_synced_out,
      .cmp2_synced_out, .latch_ext_input_pin, .true_out_pin, .true_out_pin_oe,
      .compl_out_pin, .compl_out_pin_oe);
   src_model i_src_model (.cmp1_synced_out, .cmp2_synced_out, .latch_ext_input_pin);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d, input axi_resp_t e);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(s_axi_bresp), 32'(e));
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v, input axi_resp_t e);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk("rresp", 32'(s_axi_rresp), 32'(e));
   endtask
   task t_regs;
      rd(4'h0, rv, 2'b00); chk("control", rv, 32'h0);
      rd(4'h4, rv, 2'b00); chk("enables", rv, 32'h0);
      wr(4'h4, 8'ha5, 2'b00);
      rd(4'h4, rv, 2'b00); chk("enables", rv, 32'ha5);
      wr(4'h4, 8'h00, 2'b00);
      s_axi_wstrb <= 4'he;
      wr(4'h4, 8'h3c, 2'b00);
      s_axi_wstrb <= 4'hf;
      rd(4'h4, rv, 2'b00); chk("masked", rv, 32'h0);
      wr(4'hc, 8'hff, 2'b10);
      rd(4'hc, rv, 2'b10); chk("unmapped", rv, 32'h0);
   endtask
   task t_soft;
      wr(4'h0, 8'h02, 2'b00);
      repeat (16) @(posedge clk_sys);
      rd(4'h8, rv, 2'b00); chk("state", rv, 32'h1);
      rd(4'h0, rv, 2'b00); chk("control", rv, 32'h0);
      chk("compl", 32'(compl_out_pin), 32'h0);
      wr(4'h0, 8'h73, 2'b00);
      repeat (16) @(posedge clk_sys);
      rd(4'h0, rv, 2'b00); chk("control", rv, 32'h70);
      rd(4'h8, rv, 2'b00); chk("state", rv, 32'h0);
   endtask
   task t_out;
      logic [7:0] cv [3] = '{8'h8c, 8'h0c, 8'h84};
      for (int i = 0; i < 3; i++) begin
         wr(4'h0, cv[i], 2'b00);
         repeat (3) @(posedge clk_sys);
         chk("true_oe", 32'(true_out_pin_oe), 32'(cv[i][7] & cv[i][3]));
         chk("compl_oe", 32'(compl_out_pin_oe), 32'(cv[i][7] & cv[i][2]));
      end
      wr(4'h0, 8'h00, 2'b00);
   endtask
   task t_src;
      logic [7:0] eb [6] = '{8'h10, 8'h01, 8'h20, 8'h02, 8'h80, 8'h08};
      logic [2:0] sv [6] = '{3'b001, 3'b001, 3'b010, 3'b010, 3'b100, 3'b100};
      for (int i = 0; i < 7; i++) begin
         if (i == 6) wr(4'h0, 8'h02, 2'b00);
         if (i == 6) repeat (16) @(posedge clk_sys);
         wr(4'h4, (i == 6) ? 8'h12 : eb[i], 2'b00);
         @(posedge clk_sys);
         i_src_model.put((i == 6) ? 3'b011 : sv[i]);
         repeat (4) @(posedge clk_sys);
         i_src_model.put(3'b000);
         repeat (2) @(posedge clk_sys);
         rd(4'h8, rv, 2'b00);
         chk("state", rv, 32'((i < 6) && (eb[i][7:4] != 4'h0)));
      end
   endtask
   task gap(output int k);
      k = 0;
      i_src_model.put(3'b100);
      @(posedge clk_sys);
      k++;
      i_src_model.put(3'b000);
      while (true_out_pin !== 1'b0 && k < 1100) begin @(posedge clk_sys); k++; end
      while (true_out_pin !== 1'b1 && k < 1100) begin @(posedge clk_sys); k++; end
   endtask
   task t_per;
      for (int c = 0; c < 8; c++) begin
         wr(4'h0, {1'b0, 3'(c), 4'h0}, 2'b00);
         wr(4'h4, 8'h48, 2'b00);
         gap(n);
         gap(n);
         chk("period", 32'(n), 32'(4 << c));
         wr(4'h4, 8'h00, 2'b00);
      end
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up;
      end
   end
   initial begin
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      s_axi_wstrb = 4'hf;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      t_regs;
      t_soft;
      t_out;
      t_src;
      t_per;
      wrap_up;
   end
endmodule
bind sr_latch_unit sr_latch_chk i_sr_latch_chk (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .cmp1_synced_out, .cmp2_synced_out,
   .latch_ext_input_pin, .true_out_pin, .true_out_pin_oe, .compl_out_pin, .compl_out_pin_oe);
